// ---- logic/crossbar_pkg.sv ----
package crossbar_pkg;

   // ==========================================================
   // fabric sizes
   // ==========================================================
   localparam int unsigned NUM_INPUTS = 22;
   localparam int unsigned NUM_OUTPUTS = 30;
   localparam int unsigned SEL_W = 5;
   localparam int unsigned OUT_IDX_W = 5;
   localparam int unsigned NUM_SUB = 4;
   localparam int unsigned NUM_SLOTS = 3;

   // ==========================================================
   // fixed input positions
   // ==========================================================
   localparam logic [SEL_W-1:0] IN_LOGIC_ZERO = 5'h00;
   localparam logic [SEL_W-1:0] IN_LOGIC_ONE = 5'h01;
   localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;
   localparam logic [SEL_W-1:0] SEL_LAST = 5'h15;

   // ==========================================================
   // output positions
   // ==========================================================
   localparam int unsigned OUT_PIN_BASE = 0;
   localparam int unsigned OUT_ADC_TRIG_BASE = 6;
   localparam int unsigned OUT_DAC_SYNC = 8;
   localparam int unsigned OUT_CMP_WIN_BASE = 9;
   localparam int unsigned OUT_ALT_A_BASE = 12;
   localparam int unsigned OUT_SYNC_BASE = 16;
   localparam int unsigned OUT_PWM_CLOCK = 20;
   localparam int unsigned OUT_FAULT_BASE = 21;
   localparam int unsigned OUT_FORCE = 25;
   localparam int unsigned OUT_TIMER_BASE = 26;

   // timer-input select bits 12..15 of the select register
   localparam int unsigned TSEL_BIT_BASE = 12;
   localparam int unsigned TSEL_W = 16;

   // level of each second alternate-control input after reset
   localparam logic [NUM_SUB-1:0] ALT_B_RESET = 4'h0;

   // ==========================================================
   // carriers
   // ==========================================================
   typedef struct packed {
      logic [NUM_SUB-1:0] alt_control_a;
      logic [NUM_SUB-1:0] alt_control_b;
      logic [NUM_SUB-1:0] external_sync_in;
      logic external_clock_in;
      logic [3:0] fault_input;
      logic output_force;
   } pwm_ctrl_s;

   typedef struct packed {
      logic [5:0] pin_out;
      logic [1:0] adc_trigger;
      logic dac_sync_in;
      logic [2:0] cmp_window;
   } misc_dest_s;

   typedef struct packed {
      logic [NUM_SLOTS-1:0] above_high;
      logic [NUM_SLOTS-1:0] below_low;
   } limit_cmp_s;

endpackage

// ---- logic/peripheral_crossbar_outputs.sv ----
// Overview of operation
// - Outputs 26..29 feed timer B channels 0..3 only while select bits 12..15 set.
// - Outputs 12..15 drive first alternate-control input of PWM submodules 0..3.
// - Outputs 16..19 drive external sync input of PWM submodules 0..3.
// - Output 20 is the shared external clock of the whole PWM module.
// - Output 25 drives the PWM module's external output-force input.
// - Second alternate-control of submodules 0..2 follow converter slots 0..2 limit compares.
// - Slot 0 above high limit drives low; below low limit drives high.
// - Slot 1 above high limit drives low; below low limit drives high.
// - Slot 2 above high limit drives low; below low limit drives high.
// - Submodule 3 second alternate-control is tied to logic zero.
// - Each output picks one of 22 inputs via a write-protectable select register.
// - Input to routed output path is purely combinational.
module peripheral_crossbar_outputs (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [crossbar_pkg::NUM_INPUTS-1:0] shared_input,
   input wire logic sel_write,
   input wire logic [crossbar_pkg::OUT_IDX_W-1:0] sel_write_index,
   input wire logic [crossbar_pkg::SEL_W-1:0] sel_write_value,
   input wire logic sel_write_protect,
   input wire logic [crossbar_pkg::TSEL_W-1:0] timer_input_select_reg,
   input wire logic [3:0] timer_b_default_in,
   input wire crossbar_pkg::limit_cmp_s limit_cmp,
   output logic [crossbar_pkg::NUM_OUTPUTS-1:0] routed_output_n,
   output crossbar_pkg::pwm_ctrl_s pwm_ctrl,
   output crossbar_pkg::misc_dest_s misc_dest,
   output logic [3:0] timer_b_channel_in,
   output logic [crossbar_pkg::NUM_OUTPUTS*crossbar_pkg::SEL_W-1:0] sel_readback
);

   // ==========================================================
   // select registers
   // ==========================================================
   logic [crossbar_pkg::SEL_W-1:0] sel_reg [crossbar_pkg::NUM_OUTPUTS];
   logic [crossbar_pkg::NUM_INPUTS-1:0] eff_input;
   logic write_accept;
   logic [crossbar_pkg::NUM_SLOTS-1:0] alt_b_reg;
   logic [crossbar_pkg::NUM_SLOTS-1:0] alt_b_next;
   logic [3:0] tsel;

   // first two inputs are constants regardless of what the port carries
   assign eff_input = {shared_input[crossbar_pkg::NUM_INPUTS-1:2], 1'b1, 1'b0};

   // protected select write
   // codes above the last input are dropped, so a stray write cannot pick nothing
   assign write_accept = sel_write && !sel_write_protect
      && (sel_write_value <= crossbar_pkg::SEL_LAST)
      && (32'(sel_write_index) < crossbar_pkg::NUM_OUTPUTS);

   genvar gi;
   generate
      for (gi = 0; gi < crossbar_pkg::NUM_OUTPUTS; gi++)
      begin : g_out
         always_ff @(posedge clk_sys or posedge rst)
         begin
            if (rst)
               sel_reg[gi] <= crossbar_pkg::SEL_RESET;
            else if (clk_en && write_accept && 32'(sel_write_index) == gi)
               sel_reg[gi] <= sel_write_value;
         end

         // combinational mux
         // no flop in this path: peripherals see input edges in the same cycle
         assign routed_output_n[gi] = eff_input[sel_reg[gi]];
         assign sel_readback[gi*crossbar_pkg::SEL_W +: crossbar_pkg::SEL_W] = sel_reg[gi];
      end
   endgenerate

   // ==========================================================
   // destination fan-out
   // ==========================================================
   assign misc_dest.pin_out = routed_output_n[crossbar_pkg::OUT_PIN_BASE +: 6];
   assign misc_dest.adc_trigger = routed_output_n[crossbar_pkg::OUT_ADC_TRIG_BASE +: 2];
   assign misc_dest.dac_sync_in = routed_output_n[crossbar_pkg::OUT_DAC_SYNC];
   assign misc_dest.cmp_window = routed_output_n[crossbar_pkg::OUT_CMP_WIN_BASE +: 3];
   assign pwm_ctrl.alt_control_a = routed_output_n[crossbar_pkg::OUT_ALT_A_BASE +: crossbar_pkg::NUM_SUB];
   assign pwm_ctrl.external_sync_in = routed_output_n[crossbar_pkg::OUT_SYNC_BASE +: crossbar_pkg::NUM_SUB];
   assign pwm_ctrl.external_clock_in = routed_output_n[crossbar_pkg::OUT_PWM_CLOCK];
   assign pwm_ctrl.fault_input = routed_output_n[crossbar_pkg::OUT_FAULT_BASE +: 4];
   assign pwm_ctrl.output_force = routed_output_n[crossbar_pkg::OUT_FORCE];

   // timer channel input gating
   // without the select bit the timer keeps its own pin source
   assign tsel = timer_input_select_reg[crossbar_pkg::TSEL_BIT_BASE +: 4];
   assign timer_b_channel_in = (tsel & routed_output_n[crossbar_pkg::OUT_TIMER_BASE +: 4])
      | (~tsel & timer_b_default_in);

   // ==========================================================
   // limit-compare path to second alternate control
   // ==========================================================
   // per-slot level, hold between limits
   // above-high wins if both flags are ever seen, leaning toward output off
   generate
      for (gi = 0; gi < crossbar_pkg::NUM_SLOTS; gi++)
      begin : g_slot
         assign alt_b_next[gi] = limit_cmp.above_high[gi] ? 1'b0 :
                                 limit_cmp.below_low[gi] ? 1'b1 : alt_b_reg[gi];
      end
   endgenerate

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         alt_b_reg <= crossbar_pkg::ALT_B_RESET[crossbar_pkg::NUM_SLOTS-1:0];
      else if (clk_en)
         alt_b_reg <= alt_b_next;
   end

   assign pwm_ctrl.alt_control_b = {1'b0, alt_b_reg};

   // ==========================================================
   // checks
   // ==========================================================
   sequence s_good_write;
      clk_en && write_accept;
   endsequence

   sequence s_blocked_write;
      clk_en && sel_write && sel_write_protect;
   endsequence

   // a code past the last input or an index past the last output
   sequence s_range_write;
      clk_en && sel_write && !sel_write_protect
      && (sel_write_value > crossbar_pkg::SEL_LAST || 32'(sel_write_index) >= crossbar_pkg::NUM_OUTPUTS);
   endsequence

   AST_ROUTE_COMB: assert property (@(posedge clk_sys) disable iff (rst)
      routed_output_n[7] == (sel_reg[7] == crossbar_pkg::IN_LOGIC_ONE
      || (sel_reg[7] > crossbar_pkg::IN_LOGIC_ONE && shared_input[sel_reg[7]]))
      && routed_output_n[29] == (sel_reg[29] == crossbar_pkg::IN_LOGIC_ONE
      || (sel_reg[29] > crossbar_pkg::IN_LOGIC_ONE && shared_input[sel_reg[29]])))
      else $error("routed output differs from selected input");

   AST_SEL_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
      s_good_write ##1 1'b1 |-> sel_reg[$past(sel_write_index)] == $past(sel_write_value))
      else $error("accepted select write not stored");

   AST_SEL_PROTECT: assert property (@(posedge clk_sys) disable iff (rst)
      s_blocked_write |=> $stable(sel_readback))
      else $error("protected select register changed");

   AST_TIMER_GATE: assert property (@(posedge clk_sys) disable iff (rst)
      timer_b_channel_in[2] == (timer_input_select_reg[14] ? routed_output_n[28] : timer_b_default_in[2]))
      else $error("timer channel 2 input source wrong");

   AST_ALT_A: assert property (@(posedge clk_sys) disable iff (rst)
      pwm_ctrl.alt_control_a[3] == routed_output_n[15] && pwm_ctrl.alt_control_a[0] == routed_output_n[12])
      else $error("first alternate control miswired");

   AST_SYNC: assert property (@(posedge clk_sys) disable iff (rst)
      pwm_ctrl.external_sync_in[1] == routed_output_n[17])
      else $error("external sync miswired");

   AST_CLK_FORCE: assert property (@(posedge clk_sys) disable iff (rst)
      pwm_ctrl.external_clock_in == routed_output_n[20] && pwm_ctrl.output_force == routed_output_n[25])
      else $error("clock or force miswired");

   AST_SLOT0: assert property (@(posedge clk_sys) disable iff (rst)
      clk_en && limit_cmp.above_high[0] |=> !pwm_ctrl.alt_control_b[0])
      else $error("slot 0 above high did not drive low");

   AST_SLOT1: assert property (@(posedge clk_sys) disable iff (rst)
      clk_en && limit_cmp.below_low[1] && !limit_cmp.above_high[1] |=> pwm_ctrl.alt_control_b[1])
      else $error("slot 1 below low did not drive high");

   AST_SLOT2: assert property (@(posedge clk_sys) disable iff (rst)
      clk_en && limit_cmp.below_low[2] && !limit_cmp.above_high[2]
      ##1 clk_en && limit_cmp.above_high[2] |=> !pwm_ctrl.alt_control_b[2])
      else $error("slot 2 levels wrong");

   AST_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
      !limit_cmp.above_high[0] && !limit_cmp.below_low[0] |=> $stable(pwm_ctrl.alt_control_b[0]))
      else $error("slot 0 level moved between limits");

   AST_SUB3_LOW: assert property (@(posedge clk_sys) disable iff (rst)
      !pwm_ctrl.alt_control_b[3])
      else $error("submodule 3 second alternate control not low");

   // reset, refusal and freeze: no disable on the reset check, reset itself is the trigger
   AST_SEL_RESET: assert property (@(posedge clk_sys)
      rst |=> sel_readback == '0 && routed_output_n == '0
      && pwm_ctrl.alt_control_b == crossbar_pkg::ALT_B_RESET)
      else $error("select or level not cleared by reset");

   AST_SEL_RANGE: assert property (@(posedge clk_sys) disable iff (rst)
      s_range_write |=> $stable(sel_readback))
      else $error("out-of-range select write changed a select");

   AST_SEL_FREEZE: assert property (@(posedge clk_sys) disable iff (rst)
      !clk_en |=> $stable(sel_readback) && $stable(pwm_ctrl.alt_control_b))
      else $error("state moved while clock enable low");

   // remaining fan-out wiring
   AST_TIMER_GATE_ENDS: assert property (@(posedge clk_sys) disable iff (rst)
      timer_b_channel_in[0] == (timer_input_select_reg[12] ? routed_output_n[26] : timer_b_default_in[0])
      && timer_b_channel_in[3] == (timer_input_select_reg[15] ? routed_output_n[29] : timer_b_default_in[3]))
      else $error("timer channel 0 or 3 input source wrong");

   AST_FAULT_MISC: assert property (@(posedge clk_sys) disable iff (rst)
      pwm_ctrl.fault_input == routed_output_n[24:21] && misc_dest.dac_sync_in == routed_output_n[8]
      && misc_dest.adc_trigger == routed_output_n[7:6])
      else $error("fault or converter destination miswired");

   // remaining limit levels
   AST_SLOT0_HIGH: assert property (@(posedge clk_sys) disable iff (rst)
      clk_en && limit_cmp.below_low[0] && !limit_cmp.above_high[0] |=> pwm_ctrl.alt_control_b[0])
      else $error("slot 0 below low did not drive high");

   AST_SLOT1_LOW: assert property (@(posedge clk_sys) disable iff (rst)
      clk_en && limit_cmp.above_high[1] |=> !pwm_ctrl.alt_control_b[1])
      else $error("slot 1 above high did not drive low");

   AST_SLOT2_HIGH: assert property (@(posedge clk_sys) disable iff (rst)
      clk_en && limit_cmp.below_low[2] && !limit_cmp.above_high[2] |=> pwm_ctrl.alt_control_b[2])
      else $error("slot 2 below low did not drive high");

   AST_HOLD_SLOT2: assert property (@(posedge clk_sys) disable iff (rst)
      !limit_cmp.above_high[2] && !limit_cmp.below_low[2] |=> $stable(pwm_ctrl.alt_control_b[2]))
      else $error("slot 2 level moved between limits");

endmodule

// ---- dv/adc_limit_model.sv ----
// ==========================================================
// converter window compare standing in for the far side
// ==========================================================
module adc_limit_model
(
   input wire logic [2:0][11:0] result,
   input wire logic [11:0] high_limit,
   input wire logic [11:0] low_limit,
   output crossbar_pkg::limit_cmp_s limit_cmp
);
   timeunit 1ns;
   timeprecision 1ps;
   // one limit pair for all slots keeps the bench small
   always_comb
   begin
      for (int s = 0; s < 3; s++)
      begin
         limit_cmp.above_high[s] = result[s] > high_limit;
         limit_cmp.below_low[s] = result[s] < low_limit;
      end
   end
endmodule

// ---- dv/test_peripheral_crossbar_outputs.sv ----
module test_peripheral_crossbar_outputs;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // stimulus and observed signals
   // ==========================================================
   logic clk_sys = 1'b0, rst = 1'b1, clk_en = 1'b1, sel_write = 1'b0, sel_write_protect = 1'b0;
   logic [4:0] sel_write_index = 5'h00, sel_write_value = 5'h00;
   logic [21:0] shared_input = 22'h000000;
   logic [15:0] timer_input_select_reg = 16'h0000;
   logic [3:0] timer_b_default_in = 4'h0, timer_b_channel_in;
   logic [2:0][11:0] result = 36'hf00f00f00;
   crossbar_pkg::limit_cmp_s limit_cmp;
   crossbar_pkg::pwm_ctrl_s pwm_ctrl;
   crossbar_pkg::misc_dest_s misc_dest;
   logic [29:0] routed_output_n, e;
   logic [149:0] sel_readback;
   logic [4:0] sel_exp [30];
   logic [21:0] pats [4] = '{22'h3fffff, 22'h2aaaaa, 22'h155555, 22'h000000};
   logic [35:0] rs [6] = '{36'h100100100, 36'h600600600, 36'h600f00600, 36'hf00f00f00,
      36'h100100100, 36'hf00f00f00};
   logic [3:0] ab [6] = '{4'h7, 4'h7, 4'h5, 4'h0, 4'h7, 4'h0};
   int n_errors = 0, checks_done = 0;

   peripheral_crossbar_outputs i_dut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
      .shared_input(shared_input), .sel_write(sel_write), .sel_write_index(sel_write_index),
      .sel_write_value(sel_write_value), .sel_write_protect(sel_write_protect),
      .timer_input_select_reg(timer_input_select_reg), .timer_b_default_in(timer_b_default_in),
      .limit_cmp(limit_cmp), .routed_output_n(routed_output_n), .pwm_ctrl(pwm_ctrl),
      .misc_dest(misc_dest), .timer_b_channel_in(timer_b_channel_in), .sel_readback(sel_readback));
   adc_limit_model i_adc (.result(result), .high_limit(12'h800), .low_limit(12'h400),
      .limit_cmp(limit_cmp));

   // 200 MHz
   always #2.5 clk_sys = ~clk_sys;

   // ==========================================================
   // tasks
   // ==========================================================
   task automatic check(input string name, input logic [29:0] exp, input logic [29:0] got);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // caller lowers the strobe so writes can run back to back
   task automatic write_sel(input logic [4:0] idx, input logic [4:0] val);
      sel_write = 1'b1;
      sel_write_index = idx;
      sel_write_value = val;
      @(posedge clk_sys);
      #1;
   endtask

   // no clock edge in here: the mux must settle on its own
   task automatic check_all();
      for (int i = 0; i < 30; i++)
         e[i] = (sel_exp[i] == 5'h00) ? 1'b0 : (sel_exp[i] == 5'h01) ? 1'b1 : shared_input[sel_exp[i]];
      #1;
      check("routed", e, routed_output_n);
      check("pwm", {e[15:12], e[19:16], e[20], e[24:21], e[25]}, {pwm_ctrl.alt_control_a, pwm_ctrl.external_sync_in,
         pwm_ctrl.external_clock_in, pwm_ctrl.fault_input, pwm_ctrl.output_force});
      check("misc", {e[5:0], e[7:6], e[8], e[11:9]}, misc_dest);
      check("timer", (timer_input_select_reg[15:12] & e[29:26])
         | (~timer_input_select_reg[15:12] & timer_b_default_in), timer_b_channel_in);
      for (int i = 0; i < 30; i++)
         check("sel", sel_exp[i], sel_readback[5*i +: 5]);
   endtask

   task automatic summarize();
      if (n_errors == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ==========================================================
   // tests
   // ==========================================================
   initial
   begin
      repeat (4) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      shared_input = 22'h3fffff;
      for (int i = 0; i < 30; i++)
         sel_exp[i] = 5'h00;
      check_all();
      @(posedge clk_sys);
      #1;
      // stride 7 reaches every input, the two constants included
      for (int i = 0; i < 30; i++)
      begin
         sel_exp[i] = 5'((i * 7) % 22);
         write_sel(5'(i), sel_exp[i]);
      end
      sel_write = 1'b0;
      // one pattern per cycle, so every input change sits just after an edge
      for (int k = 0; k < 4; k++)
      begin
         @(posedge clk_sys);
         #1;
         shared_input = pats[k];
         timer_input_select_reg = {pats[k][3:0], 12'h000};
         timer_b_default_in = ~pats[k][7:4];
         check_all();
      end
      // protected, frozen, bad index, bad value: all must be dropped
      for (int k = 0; k < 4; k++)
      begin
         @(posedge clk_sys);
         #1;
         sel_write_protect = (k == 0);
         clk_en = (k != 1);
         write_sel((k == 2) ? 5'h1e : 5'h02, (k == 3) ? 5'h16 : 5'h03);
         sel_write = 1'b0;
      end
      sel_write_protect = 1'b0;
      clk_en = 1'b1;
      check_all();
      @(posedge clk_sys);
      #1;
      // below, between, slot 1 above, all above, then below and above on adjacent edges
      for (int k = 0; k < 6; k++)
      begin
         result = rs[k];
         @(posedge clk_sys);
         #1;
         check("alt_b", ab[k], pwm_ctrl.alt_control_b);
      end
      summarize();
   end

   // whole run is well under a microsecond
   initial
   begin
      #5000;
      n_errors++;
      summarize();
   end
endmodule
